/* common/vpd_pkg.sv */
// Constants, types and carriers for the vital product data page responder.
// Assumes a single 50 MHz clock domain shared with the command layer.
package vpd_pkg;

  // ************************************************************
  // Page codes and page geometry
  // ************************************************************
  localparam logic [7:0] PAGE_POWER      = 8'h8d; // Power consumption page
  localparam logic [7:0] PAGE_LU_INFO    = 8'h90; // Logical unit information page
  localparam logic [7:0] PAGE_PORT_INFO  = 8'h91; // Port information page
  localparam logic [7:0] HDR_BYTE0       = 8'h00; // Qualifier 0, direct access type 0
  localparam logic [7:0] LEN_POWER       = 8'h04; // Page length of power page
  localparam logic [7:0] LEN_PORT_PAGES  = 8'h18; // Page length of 90h and 91h (24)
  localparam logic [4:0] TOTAL_POWER     = 5'h08; // Header plus body, power page
  localparam logic [4:0] TOTAL_PORT      = 5'h1c; // Header plus body, 90h and 91h
  localparam logic [4:0] DESC0_BASE      = 5'h04; // First per-port descriptor
  localparam logic [4:0] DESC1_BASE      = 5'h10; // Second per-port descriptor

  // ************************************************************
  // Field values
  // ************************************************************
  localparam logic [7:0] POWER_ID        = 8'h00; // Consumption identifier
  localparam logic [7:0] POWER_UNITS_MW  = 8'h04; // Units code 4, milliwatts, upper bits 0
  localparam logic [7:0] PORT_NUM_PRI    = 8'h01; // Relative port, primary
  localparam logic [7:0] PORT_NUM_SEC    = 8'h02; // Relative port, secondary
  localparam logic [7:0] PROTO_SSP       = 8'h06; // Protocol identifier, SAS SSP
  localparam logic [7:0] DESC_LEN_LO     = 8'h04; // Descriptor length low byte
  localparam logic [7:0] TRANSPORT_RETRY = 8'h00; // transport_retry_ctrl_support = 0
  localparam logic [7:0] POWER_CUT_BYTE  = 8'h01; // power_cut_input_supported = 1
  localparam logic [7:0] PHY_NUM_PRI     = 8'h00; // phy_number, primary port
  localparam logic [7:0] PHY_NUM_SEC     = 8'h01; // phy_number, secondary port
  localparam logic [7:0] PERSIST_BYTE    = 8'h00; // persistent_conn_capable = 0

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef enum logic {ST_IDLE, ST_SEND} fsm_e;

  // Request from the command layer (vital_page_select already decoded)
  typedef struct packed {
    logic        start;     // One-cycle request pulse
    logic [7:0]  page_code; // Page code from the command block
    logic [15:0] alloc_len; // Allocation length from the command block
  } req_s;

  // Byte stream toward the command layer
  typedef struct packed {
    logic       valid; // Byte on data is offered
    logic [7:0] data;  // Page byte
    logic       last;  // Final byte of this answer
  } stream_s;

  // Whole state of the responder
  typedef struct packed {
    fsm_e        fsm;   // Sequencer state
    logic [7:0]  code;  // Latched page code
    logic [15:0] power; // Latched maximum power value
    logic [4:0]  limit; // Bytes to send
    logic [4:0]  idx;   // Index of next byte to fetch
    stream_s     out;   // Registered stream outputs
    logic        busy;  // Answer in progress
    logic        done;  // One-cycle end of answer
    logic        unsup; // One-cycle unsupported page flag
  } state_s;

endpackage

/* hw/vpd_page_responder.sv */
// Vital product data page responder: streams the power, logical unit
// and port information pages byte by byte.
// Assumes the command layer runs on the same clock, decodes the command
// and hands over only requests with vital_page_select set.
`timescale 1ns/1ps

// Function
// - Byte zero: qualifier zero, direct access
// - Byte one echoes requested page code
// - Power page 8Dh reports length four
// - Power page byte four identifier zero
// - Power page units code four, milliwatts
// - Bytes six, seven hold maximum power
// - Page 90h length 24, two descriptors
// - Descriptor starts with relative port 1/2
// - Descriptor byte two protocol six, SSP
// - Transport retry control support bit zero
// - Page 91h length 24, two descriptors
// - Port descriptor power-cut input bit one
// - PHY descriptor at bytes 8-11 after length
// - PHY number 0 primary, 1 secondary
// - Persistent connection capable bit zero
module vpd_page_responder
  import vpd_pkg::*;
(
  input  wire logic        clk_i,          // 50 MHz clock
  input  wire logic        rst_i,          // Asynchronous reset, active high
  input  wire logic        req_start_i,    // Request pulse
  input  wire logic [7:0]  req_page_i,     // Requested page code
  input  wire logic [15:0] req_alloc_i,    // Allocation length in bytes
  input  wire logic [15:0] max_power_mw_i, // Maximum power, milliwatts
  input  wire logic        byte_ready_i,   // Command layer takes a byte
  output logic             byte_valid_o,   // Byte offered
  output logic [7:0]       byte_data_o,    // Page byte
  output logic             byte_last_o,    // Final byte of answer
  output logic             busy_o,         // Answer in progress
  output logic             done_o,         // Answer finished, one cycle
  output logic             unsupported_o   // Page code not served, one cycle
);

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Whether this block serves the page code
  function automatic logic page_known(input logic [7:0] code);
    page_known = (code == PAGE_POWER) || (code == PAGE_LU_INFO) || (code == PAGE_PORT_INFO);
  endfunction

  // Full page size, header included
  function automatic logic [4:0] page_total(input logic [7:0] code);
    if (code == PAGE_POWER) begin
      page_total = TOTAL_POWER;
    end else begin
      page_total = TOTAL_PORT;
    end
  endfunction

  // One byte of a twelve-byte per-port descriptor
  function automatic logic [7:0] desc_byte(input logic [7:0] code,
                                           input logic [3:0] off,
                                           input logic       sec);
    desc_byte = 8'h00; // Reserved bytes stay zero
    case (off)
      4'h1: begin
        desc_byte = sec ? PORT_NUM_SEC : PORT_NUM_PRI;
      end
      4'h2: begin
        desc_byte = PROTO_SSP;
      end
      4'h3: begin
        // Port page only; logical unit page keeps it reserved
        if (code == PAGE_PORT_INFO) begin
          desc_byte = POWER_CUT_BYTE;
        end
      end
      4'h7: begin
        desc_byte = DESC_LEN_LO;
      end
      4'h8: begin
        // Retry control byte on 90h, PHY byte 0 on 91h: both zero
        desc_byte = TRANSPORT_RETRY;
      end
      4'h9: begin
        if (code == PAGE_PORT_INFO) begin
          desc_byte = sec ? PHY_NUM_SEC : PHY_NUM_PRI;
        end
      end
      4'hb: begin
        desc_byte = PERSIST_BYTE;
      end
      default: begin
        desc_byte = 8'h00;
      end
    endcase
  endfunction

  // Byte at index idx of the selected page
  function automatic logic [7:0] page_byte(input logic [7:0]  code,
                                           input logic [4:0]  idx,
                                           input logic [15:0] power);
    page_byte = 8'h00;
    if (idx == 5'h00) begin
      page_byte = HDR_BYTE0;
    end else if (idx == 5'h01) begin
      page_byte = code;
    end else if (idx == 5'h02) begin
      page_byte = 8'h00; // Length high byte is zero for all served pages
    end else if (idx == 5'h03) begin
      page_byte = (code == PAGE_POWER) ? LEN_POWER : LEN_PORT_PAGES;
    end else if (code == PAGE_POWER) begin
      if (idx == 5'h04) begin
        page_byte = POWER_ID;
      end else if (idx == 5'h05) begin
        page_byte = POWER_UNITS_MW;
      end else if (idx == 5'h06) begin
        page_byte = power[15:8];
      end else if (idx == 5'h07) begin
        page_byte = power[7:0];
      end
    end else if (idx >= DESC1_BASE) begin
      page_byte = desc_byte(code, 4'(idx - DESC1_BASE), 1'b1);
    end else begin
      page_byte = desc_byte(code, 4'(idx - DESC0_BASE), 1'b0);
    end
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  state_s state_reg;  // Registered state
  state_s state_next; // Next state
  req_s   req;        // Request bundle
  logic [4:0] lim;    // Bytes allowed for the incoming request

  assign req = '{start: req_start_i, page_code: req_page_i, alloc_len: req_alloc_i};

  // Smaller of allocation length and page size
  always_comb begin
    if (req.alloc_len < 16'(page_total(req.page_code))) begin
      lim = req.alloc_len[4:0];
    end else begin
      lim = page_total(req.page_code);
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************

  // Next-state logic; pulses fall back to zero every cycle
  always_comb begin
    state_next       = state_reg;
    state_next.done  = 1'b0;
    state_next.unsup = 1'b0;
    case (state_reg.fsm)
      ST_IDLE: begin
        // Requests during an answer are ignored, so only idle looks at start
        if (req.start) begin
          if (!page_known(req.page_code)) begin
            // Other pages belong to other logic; flag and finish at once
            state_next.unsup = 1'b1;
            state_next.done  = 1'b1;
          end else if (lim == 5'h00) begin
            // Zero allocation: nothing to send
            state_next.done = 1'b1;
          end else begin
            state_next.fsm       = ST_SEND;
            state_next.busy      = 1'b1;
            state_next.code      = req.page_code;
            state_next.power     = max_power_mw_i;
            state_next.limit     = lim;
            state_next.idx       = 5'h01;
            state_next.out.valid = 1'b1;
            state_next.out.data  = page_byte(req.page_code, 5'h00, max_power_mw_i);
            state_next.out.last  = (lim == 5'h01);
          end
        end
      end
      ST_SEND: begin
        // Advance only on a taken byte; back-pressure holds the byte
        if (state_reg.out.valid && byte_ready_i) begin
          if (state_reg.out.last) begin
            state_next.fsm       = ST_IDLE;
            state_next.busy      = 1'b0;
            state_next.done      = 1'b1;
            state_next.out.valid = 1'b0;
            state_next.out.last  = 1'b0;
            state_next.out.data  = 8'h00;
          end else begin
            state_next.out.data = page_byte(state_reg.code, state_reg.idx,
                                            state_reg.power);
            state_next.out.last = (5'(state_reg.idx + 5'h01) == state_reg.limit);
            state_next.idx      = 5'(state_reg.idx + 5'h01);
          end
        end
      end
      default: begin
        state_next = '0;
      end
    endcase
  end

  // State register; constants only under reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // Outputs straight from the state register
  // ************************************************************
  assign byte_valid_o  = state_reg.out.valid;
  assign byte_data_o   = state_reg.out.data;
  assign byte_last_o   = state_reg.out.last;
  assign busy_o        = state_reg.busy;
  assign done_o        = state_reg.done;
  assign unsupported_o = state_reg.unsup;

endmodule

/* test/vpd_checker_sva.sv */
// Timing checks on the page responder's stream and status ports.
// Assumes one clock and the bind placed in the testbench top file.
`timescale 1ns/1ps
module vpd_checker
  import vpd_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        req_start_i,
  input wire logic [7:0]  req_page_i,
  input wire logic [15:0] req_alloc_i,
  input wire logic        byte_ready_i,
  input wire logic        byte_valid_o,
  input wire logic [7:0]  byte_data_o,
  input wire logic        byte_last_o,
  input wire logic        busy_o,
  input wire logic        done_o,
  input wire logic        unsupported_o
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic taken; // Request accepted this edge
  logic known; // Page code is served
  assign taken = req_start_i && !busy_o;
  assign known = req_page_i inside {PAGE_POWER, PAGE_LU_INFO, PAGE_PORT_INFO};
  property p_byte0;
    taken && known && req_alloc_i != 16'h0000 |=> byte_valid_o && byte_data_o == HDR_BYTE0;
  endproperty
  property p_echo;
    taken && known && req_alloc_i > 16'h0001 ##1 byte_ready_i
      |=> byte_valid_o && byte_data_o == $past(req_page_i, 2);
  endproperty
  property p_unsup;
    taken && !known |=> done_o && unsupported_o && !byte_valid_o;
  endproperty
  property p_zero;
    taken && known && req_alloc_i == 16'h0000 |=> done_o && !unsupported_o && !byte_valid_o;
  endproperty
  // A stalled byte must not move or vanish
  property p_hold;
    byte_valid_o && !byte_ready_i |=> byte_valid_o && $stable(byte_data_o) && $stable(byte_last_o);
  endproperty
  property p_end;
    byte_valid_o && byte_last_o && byte_ready_i |=> !byte_valid_o && done_o && !busy_o;
  endproperty
  // A request taken in the done cycle may legally end at once and pulse again
  property p_pulse;
    done_o && !taken |=> !done_o;
  endproperty
  property p_busy;
    byte_valid_o |-> busy_o && !done_o;
  endproperty
  a_byte0: assert property (p_byte0) else $error("first byte wrong");
  a_echo: assert property (p_echo) else $error("page code not echoed");
  a_unsup: assert property (p_unsup) else $error("unserved page not flagged");
  a_zero: assert property (p_zero) else $error("zero length answer wrong");
  a_hold: assert property (p_hold) else $error("stalled byte changed");
  a_end: assert property (p_end) else $error("no done after last byte");
  a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
  a_busy: assert property (p_busy) else $error("byte offered while idle");
  c_stall: cover property (byte_valid_o && !byte_ready_i);
  c_unsup: cover property (unsupported_o);
  c_end: cover property (byte_last_o && byte_ready_i);
endmodule

/* test/byte_sink.sv */
// Command layer model: takes page bytes, stalling when asked.
// Assumes valid and data are registered on the rising edge.
`timescale 1ns/1ps
module byte_sink (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       stall_i,
  input  wire logic       valid_i,
  input  wire logic [7:0] data_i,
  output logic            ready_o
);
  logic [7:0] got[$]; // Bytes taken, in order
  initial ready_o = 1'b0;
  // Ready moves off the sampling edge; toggling hits every stall phase
  always @(negedge clk_i) ready_o <= rst_i ? 1'b0 : (stall_i ? ~ready_o : 1'b1);
  // A byte counts only where valid and ready meet
  always @(posedge clk_i) if (!rst_i && valid_i && ready_o) got.push_back(data_i);
endmodule

/* test/tb_top.sv */
// Testbench: requests each page, compares streamed bytes with tables.
// Assumes the sink model and checker compiled before this file.
`timescale 1ns/1ps
module tb_top;
  import vpd_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, req_start_i = 1'b0, stall = 1'b0;
  logic [7:0] req_page_i = 8'h00, byte_data_o;
  logic [15:0] req_alloc_i = 16'h0000, max_power_mw_i = 16'h0000;
  logic byte_ready_i, byte_valid_o, byte_last_o, busy_o, done_o, unsupported_o;
  int fails = 0, compares = 0;
  always #10 clk_i = ~clk_i;
  vpd_page_responder dut (.clk_i(clk_i), .rst_i(rst_i), .req_start_i(req_start_i),
    .req_page_i(req_page_i), .req_alloc_i(req_alloc_i), .max_power_mw_i(max_power_mw_i),
    .byte_ready_i(byte_ready_i), .byte_valid_o(byte_valid_o), .byte_data_o(byte_data_o),
    .byte_last_o(byte_last_o), .busy_o(busy_o), .done_o(done_o),
    .unsupported_o(unsupported_o));
  byte_sink sink (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .valid_i(byte_valid_o),
    .data_i(byte_data_o), .ready_o(byte_ready_i));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic stop_test();
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Expected page byte, big-endian fields, reserved places zero
  function automatic logic [7:0] exp_byte(logic [7:0] pg, int i, logic [15:0] pw);
    int d;
    logic sec;
    sec = i >= 16;
    d = sec ? i - 16 : i - 4;
    if (i < 4) return i == 1 ? pg : (i == 3 ? (pg == 8'h8d ? 8'h04 : 8'h18) : 8'h00);
    if (pg == 8'h8d) return i == 5 ? 8'h04 : (i == 6 ? pw[15:8] : (i == 7 ? pw[7:0] : 8'h00));
    case (d)
      1: return sec ? 8'h02 : 8'h01;
      2: return 8'h06;
      3: return pg == 8'h91 ? 8'h01 : 8'h00;
      7: return 8'h04;
      9: return (pg == 8'h91 && sec) ? 8'h01 : 8'h00;
      default: return 8'h00;
    endcase
  endfunction
  // One request; poke fires a second start while busy, which must be ignored
  task automatic run(logic [7:0] pg, logic [15:0] al, logic [15:0] pw, logic poke);
    int n;
    int k;
    logic uns;
    @(negedge clk_i);
    sink.got.delete();
    req_page_i = pg;
    req_alloc_i = al;
    max_power_mw_i = pw;
    req_start_i = 1'b1;
    @(negedge clk_i);
    req_start_i = 1'b0;
    max_power_mw_i = ~pw;
    if (poke) begin
      req_page_i = 8'h8d;
      req_start_i = 1'b1;
      @(negedge clk_i);
      req_start_i = 1'b0;
    end
    k = 0;
    while (done_o !== 1'b1) begin
      @(negedge clk_i);
      k++;
      if (k > 300) begin
        fails++;
        stop_test();
      end
    end
    uns = !(pg inside {8'h8d, 8'h90, 8'h91});
    n = uns ? 0 : (al < (pg == 8'h8d ? 8 : 28) ? al : (pg == 8'h8d ? 8 : 28));
    check("unsupported", unsupported_o, uns);
    check("busy", busy_o, 16'h0000);
    check("count", sink.got.size(), n);
    for (int i = 0; i < n; i++) begin
      check("byte", sink.got[i], exp_byte(pg, i, pw));
    end
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (10) @(negedge clk_i);
    check("reset", {byte_valid_o, byte_last_o, busy_o, done_o, unsupported_o}, 16'h0000);
    rst_i = 1'b0;
    run(8'h8d, 16'h0100, 16'h1a2b, 1'b0);
    run(8'h8d, 16'h0003, 16'h1a2b, 1'b0);
    run(8'h8d, 16'h0000, 16'h1a2b, 1'b0);
    stall = 1'b1;
    run(8'h90, 16'hffff, 16'hc3d4, 1'b1);
    run(8'h91, 16'h001c, 16'h0000, 1'b1);
    run(8'h91, 16'h001b, 16'h0000, 1'b0);
    run(8'h8a, 16'h0040, 16'h0000, 1'b0);
    stall = 1'b0;
    // Reset in the middle of an answer must drop the stream at once
    @(negedge clk_i);
    req_page_i = 8'h91;
    req_alloc_i = 16'h001c;
    req_start_i = 1'b1;
    @(negedge clk_i);
    req_start_i = 1'b0;
    repeat (3) @(negedge clk_i);
    check("midstream", byte_valid_o, 16'h0001);
    rst_i = 1'b1;
    @(negedge clk_i);
    check("midreset", {byte_valid_o, byte_last_o, busy_o, done_o}, 16'h0000);
    rst_i = 1'b0;
    run(8'h90, 16'h001d, 16'h0000, 1'b0);
    stop_test();
  end
endmodule
bind vpd_page_responder vpd_checker chk (.clk_i(clk_i), .rst_i(rst_i),
  .req_start_i(req_start_i), .req_page_i(req_page_i), .req_alloc_i(req_alloc_i),
  .byte_ready_i(byte_ready_i), .byte_valid_o(byte_valid_o), .byte_data_o(byte_data_o),
  .byte_last_o(byte_last_o), .busy_o(busy_o), .done_o(done_o),
  .unsupported_o(unsupported_o));
